// File: rtl/wsm_cfg.svh
// Constants of the watch set-mode sequencer
`ifndef WSM_CFG_SVH
`define WSM_CFG_SVH
`define WSM_CLK_HZ        10000000
`define WSM_HALF_SEC_MS   500
`define WSM_PRESS_COUNT   3'h5
`define WSM_GAP_HT        4'h4
`define WSM_TIMEOUT_HT    4'hC
`define WSM_IDLE_MAX      4'hF
`define WSM_SEC_MAX       6'h3B
`define WSM_MIN_MAX       6'h3B
`define WSM_HOUR_MAX      6'h17
`define WSM_DAY_MAX       6'h06
`define WSM_MONTH_MAX     6'h0C
`define WSM_LEAP_MAX      6'h04
`define WSM_FEB_DAYS      6'h1C
`define WSM_FEB_LEAP_DAYS 6'h1D
`define WSM_RST_SEC       6'h00
`define WSM_RST_MIN       6'h00
`define WSM_RST_HOUR      5'h00
`define WSM_RST_DATE      5'h01
`define WSM_RST_DAY       3'h0
`define WSM_RST_MONTH     4'h1
`define WSM_RST_LEAP      3'h1
`endif

// File: rtl/wsm_pkg.sv
// Types of the watch set-mode sequencer
package wsm_pkg;
  typedef enum logic [2:0] {
    ST_TIME, ST_ENTRY, ST_MONTH, ST_DATE, ST_DAY, ST_HOUR, ST_MIN
  } wsm_state_t;
  typedef struct packed {
    wsm_state_t mode;
    logic       show_cal;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
    logic [4:0] date;
    logic [2:0] day;
    logic [3:0] month;
    logic [2:0] leap;
    logic       am_ind;
    logic       pm_ind;
    logic       hr_ind;
    logic       blank_hour;
    logic       blank_date;
    logic       blank_month;
    logic       colon_on;
  } wsm_disp_t;
endpackage

// File: rtl/wsm_top.sv
// Watch time keeping and single-button set-mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "wsm_cfg.svh"
module wsm_top #(
  parameter int HALF_SEC_CYCLES = `WSM_CLK_HZ / 1000 * `WSM_HALF_SEC_MS
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         push_button_input,
  input  wire logic         hour_format_select,
  output wsm_pkg::wsm_disp_t disp_ff
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] wrap_inc(input logic [5:0] v, input logic [5:0] lo,
                                          input logic [5:0] hi);
    wrap_inc = (v >= hi) ? lo : v + 6'h01;
  endfunction
  function automatic logic [5:0] month_days(input logic [3:0] m, input logic [2:0] y);
    case (m)
      4'h2:                      month_days = (y == 3'h4) ? `WSM_FEB_LEAP_DAYS : `WSM_FEB_DAYS;
      4'h4, 4'h6, 4'h9, 4'hB:    month_days = 6'h1E;
      default:                   month_days = 6'h1F;
    endcase
  endfunction
  function automatic wsm_pkg::wsm_state_t set_next(input wsm_pkg::wsm_state_t s);
    case (s)
      wsm_pkg::ST_MONTH: set_next = wsm_pkg::ST_DATE;
      wsm_pkg::ST_DATE:  set_next = wsm_pkg::ST_DAY;
      wsm_pkg::ST_DAY:   set_next = wsm_pkg::ST_HOUR;
      wsm_pkg::ST_HOUR:  set_next = wsm_pkg::ST_MIN;
      default:           set_next = wsm_pkg::ST_TIME;
    endcase
  endfunction

  wsm_pkg::wsm_state_t state_ff;
  logic [22:0] div_ff;
  logic        phase_ff;
  logic        btn_s1_ff;
  logic        btn_s2_ff;
  logic        btn_prev_ff;
  logic        fmt_s1_ff;
  logic        fmt_s2_ff;
  logic [3:0]  idle_ff;
  logic [2:0]  cnt_ff;
  logic [1:0]  hold_ff;
  logic        armed_ff;
  logic        sec_hold_ff;
  logic        cal_ff;
  logic [5:0]  sec_ff;
  logic [5:0]  min_ff;
  logic [4:0]  hour_ff;
  logic [4:0]  date_ff;
  logic [2:0]  day_ff;
  logic [3:0]  month_ff;
  logic [2:0]  leap_ff;

  // ----------------------------------------------------------------
  // Time base and button
  // ----------------------------------------------------------------
  logic half_tick;
  logic sec_tick;
  logic press;
  logic rel;
  logic in_set;
  logic timeout;
  logic sync_press;
  logic enter_hit;
  logic auto_inc;
  logic inc_set;
  logic [5:0] dim;
  assign half_tick  = (div_ff == 23'(HALF_SEC_CYCLES - 1));
  assign sec_tick   = half_tick & phase_ff;
  assign press      = btn_s2_ff & ~btn_prev_ff;
  assign rel        = ~btn_s2_ff & btn_prev_ff;
  assign in_set     = (state_ff >= wsm_pkg::ST_MONTH);
  assign timeout    = in_set & half_tick & ~btn_s2_ff &
                      (idle_ff == `WSM_TIMEOUT_HT - 4'h1);
  assign sync_press = (state_ff == wsm_pkg::ST_TIME) & press & armed_ff;
  assign enter_hit  = (state_ff == wsm_pkg::ST_TIME) & press & ~armed_ff &
                      (idle_ff < `WSM_GAP_HT) &
                      (cnt_ff == `WSM_PRESS_COUNT - 3'h1);
  // Roll starts on the third tick of a hold, so a short tap never rolls; then 1 Hz
  assign auto_inc   = in_set & btn_s2_ff & ~press & half_tick &
                      (hold_ff == 2'h2);
  assign inc_set    = in_set & (press | auto_inc);
  assign dim        = month_days(month_ff, leap_ff);

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      div_ff   <= 23'h000000;
      phase_ff <= 1'b0;
    end
    else
    begin
      div_ff   <= half_tick ? 23'h000000 : div_ff + 23'h000001;
      phase_ff <= phase_ff ^ half_tick;
    end

  // Pins pass two flops before any logic looks at them
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      btn_s1_ff   <= 1'b0;
      btn_s2_ff   <= 1'b0;
      btn_prev_ff <= 1'b0;
      fmt_s1_ff   <= 1'b0;
      fmt_s2_ff   <= 1'b0;
    end
    else
    begin
      btn_s1_ff   <= push_button_input;
      btn_s2_ff   <= btn_s1_ff;
      btn_prev_ff <= btn_s2_ff;
      fmt_s1_ff   <= hour_format_select;
      fmt_s2_ff   <= fmt_s1_ff;
    end

  // Half seconds since last release or timeout; held button keeps it at zero
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      idle_ff <= `WSM_IDLE_MAX;
    else if (btn_s2_ff || timeout)
      idle_ff <= 4'h0;
    else if (half_tick && idle_ff != `WSM_IDLE_MAX)
      idle_ff <= idle_ff + 4'h1;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      hold_ff <= 2'h0;
    else if (press || !btn_s2_ff)
      hold_ff <= 2'h0;
    else if (half_tick)
      hold_ff <= (hold_ff == 2'h2) ? 2'h1 : hold_ff + 2'h1;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cnt_ff <= 3'h0;
    else if (state_ff != wsm_pkg::ST_TIME || enter_hit)
      cnt_ff <= 3'h0;
    else if (press && !armed_ff)
      cnt_ff <= (idle_ff >= `WSM_GAP_HT) ? 3'h1 : cnt_ff + 3'h1;

  // ----------------------------------------------------------------
  // Mode sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      state_ff <= wsm_pkg::ST_TIME;
    else
      case (state_ff)
        wsm_pkg::ST_TIME:
          if (enter_hit)
            state_ff <= wsm_pkg::ST_ENTRY;
        wsm_pkg::ST_ENTRY:
          if (rel)
            state_ff <= wsm_pkg::ST_MONTH;
        default:
          if (timeout)
            state_ff <= set_next(state_ff);
      endcase

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      armed_ff <= 1'b0;
    else if (state_ff == wsm_pkg::ST_MIN && inc_set)
      armed_ff <= 1'b1;
    else if (sync_press)
      armed_ff <= 1'b0;

  // Set wins over the release clear
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      sec_hold_ff <= 1'b0;
    else if (sync_press)
      sec_hold_ff <= 1'b1;
    else if (rel)
      sec_hold_ff <= 1'b0;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cal_ff <= 1'b0;
    else if (state_ff != wsm_pkg::ST_TIME || sync_press)
      cal_ff <= 1'b0;
    else if (press)
      cal_ff <= 1'b1;
    else if (!btn_s2_ff && idle_ff >= `WSM_GAP_HT)
      cal_ff <= 1'b0;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // A set step pre-empts a tick landing in the same cycle; it costs one second at most
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      sec_ff   <= `WSM_RST_SEC;
      min_ff   <= `WSM_RST_MIN;
      hour_ff  <= `WSM_RST_HOUR;
      date_ff  <= `WSM_RST_DATE;
      day_ff   <= `WSM_RST_DAY;
      month_ff <= `WSM_RST_MONTH;
      leap_ff  <= `WSM_RST_LEAP;
    end
    else if (inc_set)
      case (state_ff)
        wsm_pkg::ST_MONTH:
        begin
          month_ff <= 4'(wrap_inc({2'h0, month_ff}, 6'h01, `WSM_MONTH_MAX));
          if (month_ff == 4'(`WSM_MONTH_MAX))
            leap_ff <= 3'(wrap_inc({3'h0, leap_ff}, 6'h01, `WSM_LEAP_MAX));
        end
        wsm_pkg::ST_DATE:
          date_ff <= 5'(wrap_inc({1'h0, date_ff}, 6'h01, dim));
        wsm_pkg::ST_DAY:
          day_ff  <= 3'(wrap_inc({3'h0, day_ff}, 6'h00, `WSM_DAY_MAX));
        wsm_pkg::ST_HOUR:
          hour_ff <= 5'(wrap_inc({1'h0, hour_ff}, 6'h00, `WSM_HOUR_MAX));
        default:
          min_ff  <= wrap_inc(min_ff, 6'h00, `WSM_MIN_MAX);
      endcase
    else if (sync_press || sec_hold_ff)
      sec_ff <= 6'h00;
    else if (sec_tick)
    begin
      sec_ff <= wrap_inc(sec_ff, 6'h00, `WSM_SEC_MAX);
      if (sec_ff == `WSM_SEC_MAX)
      begin
        min_ff <= wrap_inc(min_ff, 6'h00, `WSM_MIN_MAX);
        if (min_ff == `WSM_MIN_MAX)
        begin
          hour_ff <= 5'(wrap_inc({1'h0, hour_ff}, 6'h00, `WSM_HOUR_MAX));
          if (hour_ff == 5'(`WSM_HOUR_MAX))
          begin
            day_ff  <= 3'(wrap_inc({3'h0, day_ff}, 6'h00, `WSM_DAY_MAX));
            date_ff <= 5'(wrap_inc({1'h0, date_ff}, 6'h01, dim));
            if ({1'h0, date_ff} >= dim)
            begin
              month_ff <= 4'(wrap_inc({2'h0, month_ff}, 6'h01, `WSM_MONTH_MAX));
              if (month_ff == 4'(`WSM_MONTH_MAX))
                leap_ff <= 3'(wrap_inc({3'h0, leap_ff}, 6'h01, `WSM_LEAP_MAX));
            end
          end
        end
      end
    end

  // ----------------------------------------------------------------
  // Display
  // ----------------------------------------------------------------
  logic [4:0] hour_shown;
  assign hour_shown = !fmt_s2_ff ? hour_ff :
                      (hour_ff == 5'h00) ? 5'h0C :
                      (hour_ff > 5'h0C) ? hour_ff - 5'h0C : hour_ff;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      disp_ff <= '0;
    else
    begin
      disp_ff.mode        <= state_ff;
      disp_ff.show_cal    <= cal_ff;
      disp_ff.hour        <= hour_shown;
      disp_ff.min         <= min_ff;
      disp_ff.sec         <= sec_ff;
      disp_ff.date        <= date_ff;
      disp_ff.day         <= day_ff;
      disp_ff.month       <= month_ff;
      disp_ff.leap        <= leap_ff;
      disp_ff.am_ind      <= fmt_s2_ff & (hour_ff < 5'h0C);
      disp_ff.pm_ind      <= fmt_s2_ff & (hour_ff >= 5'h0C);
      disp_ff.hr_ind      <= ~fmt_s2_ff;
      disp_ff.blank_hour  <= hour_shown < 5'h0A;
      disp_ff.blank_date  <= date_ff < 5'h0A;
      disp_ff.blank_month <= month_ff < 4'hA;
      disp_ff.colon_on    <= (state_ff == wsm_pkg::ST_TIME) | phase_ff;
    end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_entry_fifth_press: assert property (($past(state_ff) == wsm_pkg::ST_TIME &&
    state_ff == wsm_pkg::ST_ENTRY) |-> ($past(press) && $past(cnt_ff) == 3'h4))
    else $error("Set entry without five presses");
  a_entry_on_release: assert property (($past(state_ff) == wsm_pkg::ST_ENTRY &&
    state_ff != wsm_pkg::ST_ENTRY) |-> (state_ff == wsm_pkg::ST_MONTH && $past(rel)))
    else $error("Entry left other than by release to month");
  a_set_order: assert property (($past(in_set) && state_ff != $past(state_ff)) |->
    (state_ff == set_next($past(state_ff))))
    else $error("Setting states out of order");
  a_timeout_six: assert property (($past(in_set) && state_ff != $past(state_ff)) |->
    ($past(idle_ff) == 4'hB && $past(half_tick) && !$past(btn_s2_ff)))
    else $error("Set state left before six seconds idle");
  a_press_min_step: assert property ((state_ff == wsm_pkg::ST_MIN && press) |=>
    (min_ff == (($past(min_ff) == 6'h3B) ? 6'h00 : $past(min_ff) + 6'h01)))
    else $error("Minute press did not step by one");
  a_no_carry: assert property ((state_ff == wsm_pkg::ST_HOUR && inc_set) |=>
    ($stable(day_ff) && $stable(date_ff)))
    else $error("Hour set carried into calendar");
  a_leap_wrap: assert property (($past(month_ff) == 4'hC && month_ff == 4'h1) |->
    (leap_ff == (($past(leap_ff) == 3'h4) ? 3'h1 : $past(leap_ff) + 3'h1)))
    else $error("Leap counter did not follow month wrap");
  a_feb_length: assert property ((month_ff == 4'h2) |->
    (date_ff <= ((leap_ff == 3'h4) ? 5'h1D : 5'h1C)))
    else $error("February date out of range");
  a_sec_held: assert property (sec_hold_ff |=> (sec_ff == 6'h00))
    else $error("Seconds not held at zero");
  a_colon_steady: assert property ((state_ff == wsm_pkg::ST_TIME) |=> disp_ff.colon_on)
    else $error("Colon not steady in time display");
  a_colon_blink: assert property ((in_set && $past(in_set)) |=>
    (disp_ff.colon_on == $past(phase_ff)))
    else $error("Colon not blinking in set state");

  c_enter_set: cover property (state_ff == wsm_pkg::ST_ENTRY ##[1:1000] state_ff == wsm_pkg::ST_MONTH);
  c_min_exit: cover property ($past(state_ff) == wsm_pkg::ST_MIN && state_ff == wsm_pkg::ST_TIME);
  c_sec_sync: cover property (sync_press ##1 sec_hold_ff);
  c_auto_roll: cover property (auto_inc);
endmodule
`default_nettype wire

// File: tb/wsm_button_model.sv
// Push-button model standing in for the watch wearer
`timescale 1ns/1ps
`default_nettype none
module wsm_button_model (
  input  wire logic clk,
  output var  logic push_button_input
);
  initial push_button_input = 1'b0;
  // ----------------------------------------
  // Press and release
  // ----------------------------------------
  // Levels change just after a falling edge, well clear of the sampling edge
  task automatic press(input int n);
    @(negedge clk);
    push_button_input = 1'b1;
    repeat (n) @(negedge clk);
  endtask
  task automatic release_for(input int n);
    push_button_input = 1'b0;
    repeat (n) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the watch set-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic               clk;
  logic               rst_b;
  logic               hour_format_select;
  wire logic          push_button_input;
  wsm_pkg::wsm_disp_t disp_ff;
  int                 errors;
  int                 samples_checked;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  wsm_button_model btn_u (.clk(clk), .push_button_input(push_button_input));
  // Four cycles per half second keeps every timeout short
  wsm_top #(.HALF_SEC_CYCLES(4)) dut_u (
    .clk               (clk),
    .rst_b             (rst_b),
    .push_button_input (push_button_input),
    .hour_format_select(hour_format_select),
    .disp_ff           (disp_ff)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic tap(input int n);
    repeat (n)
    begin
      btn_u.press(6);
      btn_u.release_for(6);
    end
  endtask
  task automatic wait_mode(input wsm_pkg::wsm_state_t m, input int lim);
    int i;
    i = 0;
    while (disp_ff.mode !== m && i < lim)
    begin
      @(negedge clk);
      i++;
    end
    chk(disp_ff.mode === m, "mode not reached in time");
  endtask
  function automatic int fwd(input logic [5:0] a, input logic [5:0] b);
    return (int'(b) - int'(a) + 60) % 60;
  endfunction
  task automatic close_out();
    $display("errors %0d, samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic run_reset();
    chk(disp_ff.hr_ind === 1'b1 && disp_ff.am_ind === 1'b0, "24h indicator");
    chk(disp_ff.pm_ind === 1'b0, "pm shown in 24h");
    chk(disp_ff.blank_hour && disp_ff.blank_date && disp_ff.blank_month, "blanking");
    chk(disp_ff.leap === 3'h1 && disp_ff.colon_on === 1'b1, "reset view");
  endtask
  task automatic run_entry();
    int ones;
    ones = 0;
    tap(4);
    chk(disp_ff.show_cal === 1'b1, "calendar view not shown");
    repeat (30) @(negedge clk);
    chk(disp_ff.mode === wsm_pkg::ST_TIME, "entry after four presses");
    chk(disp_ff.show_cal === 1'b0, "calendar view not cleared");
    tap(4);
    btn_u.press(6);
    chk(disp_ff.mode === wsm_pkg::ST_ENTRY, "fifth press held");
    btn_u.release_for(1);
    wait_mode(wsm_pkg::ST_MONTH, 10);
    repeat (16)
    begin
      @(negedge clk);
      if (disp_ff.colon_on === 1'b1) ones++;
    end
    chk(ones > 0 && ones < 16, "colon not blinking");
  endtask
  task automatic run_month();
    tap(1);
    chk(disp_ff.month === 4'h2, "month step");
    tap(10);
    chk(disp_ff.month === 4'hC && disp_ff.blank_month === 1'b0, "month 12");
    tap(1);
    chk(disp_ff.month === 4'h1 && disp_ff.leap === 3'h2, "month wrap");
    chk(disp_ff.date === 5'h01, "wrap carried upward");
  endtask
  task automatic run_steps();
    wait_mode(wsm_pkg::ST_DATE, 60);
    tap(1);
    chk(disp_ff.date === 5'h02 && disp_ff.blank_date === 1'b1, "date step");
    repeat (34) @(negedge clk);
    chk(disp_ff.mode === wsm_pkg::ST_DATE, "left date early");
    wait_mode(wsm_pkg::ST_DAY, 30);
    wait_mode(wsm_pkg::ST_HOUR, 70);
    wait_mode(wsm_pkg::ST_MIN, 70);
  endtask
  task automatic run_minutes();
    logic [5:0] m0;
    m0 = disp_ff.min;
    tap(1);
    chk(fwd(m0, disp_ff.min) inside {[1:2]}, "minute step");
    m0 = disp_ff.min;
    btn_u.press(40);
    chk(fwd(m0, disp_ff.min) inside {[3:7]}, "no roll while held");
    btn_u.release_for(1);
    wait_mode(wsm_pkg::ST_TIME, 80);
    repeat (10)
    begin
      @(negedge clk);
      chk(disp_ff.colon_on === 1'b1, "colon not steady");
    end
  endtask
  task automatic run_sync();
    int i;
    hour_format_select = 1'b1;
    btn_u.press(20);
    chk(disp_ff.sec === 6'h00, "seconds not held");
    chk((disp_ff.am_ind | disp_ff.pm_ind) === 1'b1 && !disp_ff.hr_ind, "12h view");
    btn_u.release_for(4);
    chk(disp_ff.sec === 6'h00, "seconds moved at release");
    i = 0;
    while (disp_ff.sec === 6'h00 && i < 20)
    begin
      @(negedge clk);
      i++;
    end
    chk(disp_ff.sec === 6'h01, "seconds did not restart");
    hour_format_select = 1'b0;
    repeat (4) @(negedge clk);
    chk(disp_ff.hr_ind === 1'b1 && disp_ff.pm_ind === 1'b0, "24h view back");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    hour_format_select = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    run_reset();
    run_entry();
    run_month();
    run_steps();
    run_minutes();
    run_sync();
    close_out();
  end
  // The scenarios need under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
